/* rcr_flag_cell.sv */
`timescale 1ns/1ns
// one sticky flag: wipe first, then set, then write-one clear
module rcr_flag_cell #(
    parameter logic RESET_VAL = 1'b0
) (
    input  wire logic core_clk,
    input  wire logic reset_n,
    input  wire logic wipe,
    input  wire logic set,
    input  wire logic clear,
    output logic      flag_q
);
    // set beats a clear in the same cycle so no event is lost
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            flag_q <= RESET_VAL;
        end else if (wipe) begin
            flag_q <= 1'b0;
        end else if (set) begin
            flag_q <= 1'b1;
        end else if (clear) begin
            flag_q <= 1'b0;
        end
    end
endmodule

/* rcr_pkg.sv */
// What this block does
// - non-power-on reset sets only its own flag
// - startup flag follows current start-up, not retained
// - power-on clears cause, safety and start-up flags (not irq status), sets power-on flag
// - flags read one when set, write-one clears, except the read-only bit 7
// - bit 0 set by power-on or debug reset
// - bit 3 bad watchdog clear, bit 2 overflow
// - bit 6 reset pin, bit 4 supervisor
// - bit 8 break reset when level two plus
// - bit 7 read-only start-up abnormality flag
// - status as word or two byte addresses
// - safety status byte-only at its own address
// - safety bit 1 parity, bit 0 rom access
// - low pin holds reset and sets flag
package rcr_pkg;
    // register indices (byte address is four times the index)
    localparam logic [15:0] IDX_STATUS      = 16'hF058;
    localparam logic [15:0] IDX_STATUS_HIGH = 16'hF059;
    localparam logic [15:0] IDX_SAFETY      = 16'hF05A;
    localparam logic [15:0] IDX_IRQ_STATUS  = 16'hF060;
    localparam logic [15:0] IDX_IRQ_MASK    = 16'hF061;
    // cause status field positions
    localparam int BIT_POWER_ON    = 0;
    localparam int BIT_WDT_OVF     = 2;
    localparam int BIT_WDT_BAD     = 3;
    localparam int BIT_SUPERVISOR  = 4;
    localparam int BIT_PIN         = 6;
    localparam int BIT_STARTUP     = 7;
    localparam int BIT_BREAK       = 8;
    // safety status field positions
    localparam int BIT_ROM_ACCESS  = 0;
    localparam int BIT_RAM_PARITY  = 1;
    // writable cause bits, bit 7 is the start-up flag, everything else reserved
    localparam logic [15:0] CAUSE_MASK     = 16'h015D;
    localparam logic [7:0]  SAFETY_MASK    = 8'h03;
    // reset values
    localparam logic [15:0] STATUS_RESET   = 16'h0001;
    localparam logic [7:0]  SAFETY_RESET   = 8'h00;
    localparam logic [7:0]  IRQ_MASK_RESET = 8'h00;
    // break reset qualifying exception level
    localparam logic [1:0]  BREAK_MIN_LEVEL = 2'h2;
    // interrupt event bit positions
    localparam int IRQ_POWER_ON   = 0;
    localparam int IRQ_WDT_OVF    = 1;
    localparam int IRQ_WDT_BAD    = 2;
    localparam int IRQ_SUPERVISOR = 3;
    localparam int IRQ_PIN        = 4;
    localparam int IRQ_BREAK      = 5;
    localparam int IRQ_RAM_PARITY = 6;
    localparam int IRQ_ROM_ACCESS = 7;
    // bus answer state
    typedef enum logic [0:0] {
        RCR_BUS_IDLE = 1'b0,
        RCR_BUS_ACK  = 1'b1
    } rcr_bus_e;
endpackage

/* rcr_reset_cause_recorder.sv */
`timescale 1ns/1ns
module rcr_reset_cause_recorder (
    input  wire logic        core_clk,          // 125 MHz
    input  wire logic        reset_n,           // synchronous, active low
    // avalon-mm slave, word addressed
    input  wire logic [15:0] avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    // reset sources
    input  wire logic        reset_pin_n,       // external pin, asynchronous
    input  wire logic        por_detect,        // one-cycle pulses below, except the exception_level and startup_abnormal levels
    input  wire logic        debug_cmd_reset,
    input  wire logic        wdt_overflow,
    input  wire logic        wdt_bad_clear,
    input  wire logic        supervisor_trip,
    input  wire logic        brk_exec,
    input  wire logic [1:0]  exception_level,
    input  wire logic        ram_parity_error,
    input  wire logic        unused_rom_access,
    input  wire logic        startup_done,      // pulse at end of start-up
    input  wire logic        startup_abnormal,  // level, valid with startup_done
    // outputs
    output logic             system_reset_hold,
    output logic             cpu_reset_req,
    output logic             irq
);

    ////////////////////////////////////////////////////////////////////////////
    // reset pin synchroniser

    logic pin_meta_q;                // first stage, read by second only
    logic pin_sync_q;                // synchronised pin level
    logic pin_prev_q;                // previous synchronised level
    logic pin_fall;                  // pin just went low

    // two flops before any logic looks at the pin
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            pin_meta_q <= 1'b1;
            pin_sync_q <= 1'b1;
            pin_prev_q <= 1'b1;
        end else begin
            pin_meta_q <= reset_pin_n;
            pin_sync_q <= pin_meta_q;
            pin_prev_q <= pin_sync_q;
        end
    end

    assign pin_fall = pin_prev_q & ~pin_sync_q;

    // hold the device in reset while the pin stays low
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            system_reset_hold <= 1'b0;
        end else begin
            system_reset_hold <= ~pin_sync_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // event decode

    logic        por_evt;            // power-on or debug command reset
    logic        brk_evt;            // qualified break reset
    logic [15:0] cause_set;          // per-bit set requests
    logic [7:0]  safety_set;         // safety set requests
    logic [7:0]  irq_evt;            // interrupt events

    assign por_evt = por_detect | debug_cmd_reset;
    assign brk_evt = brk_exec & (exception_level >= rcr_pkg::BREAK_MIN_LEVEL);

    // only the causing bit is raised
    always_comb begin
        cause_set = 16'h0000;
        cause_set[rcr_pkg::BIT_POWER_ON]   = por_evt;
        cause_set[rcr_pkg::BIT_WDT_OVF]    = wdt_overflow;
        cause_set[rcr_pkg::BIT_WDT_BAD]    = wdt_bad_clear;
        cause_set[rcr_pkg::BIT_SUPERVISOR] = supervisor_trip;
        cause_set[rcr_pkg::BIT_PIN]        = pin_fall;
        cause_set[rcr_pkg::BIT_BREAK]      = brk_evt;
    end

    // safety causes
    always_comb begin
        safety_set = 8'h00;
        safety_set[rcr_pkg::BIT_RAM_PARITY] = ram_parity_error;
        safety_set[rcr_pkg::BIT_ROM_ACCESS] = unused_rom_access;
    end

    // interrupt event layout
    always_comb begin
        irq_evt = 8'h00;
        irq_evt[rcr_pkg::IRQ_POWER_ON]   = por_evt;
        irq_evt[rcr_pkg::IRQ_WDT_OVF]    = wdt_overflow;
        irq_evt[rcr_pkg::IRQ_WDT_BAD]    = wdt_bad_clear;
        irq_evt[rcr_pkg::IRQ_SUPERVISOR] = supervisor_trip;
        irq_evt[rcr_pkg::IRQ_PIN]        = pin_fall;
        irq_evt[rcr_pkg::IRQ_BREAK]      = brk_evt;
        irq_evt[rcr_pkg::IRQ_RAM_PARITY] = ram_parity_error;
        irq_evt[rcr_pkg::IRQ_ROM_ACCESS] = unused_rom_access;
    end

    // cpu-only reset request pulse
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            cpu_reset_req <= 1'b0;
        end else begin
            cpu_reset_req <= brk_evt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // avalon slave: one wait cycle, answer on the second

    rcr_pkg::rcr_bus_e bus_q;        // answer state
    logic        req;                // request present
    logic        take;               // edge where the request completes
    logic        wr_take;            // write completes now
    logic [15:0] status_wr;          // write-one strobes to cause bits
    logic [7:0]  safety_wr;          // write-one strobes to safety bits
    logic [7:0]  irq_wr;             // write-one strobes to irq status
    logic [31:0] rd_d;               // read data next value

    assign req     = avs_read | avs_write;
    assign take    = req & (bus_q == rcr_pkg::RCR_BUS_ACK);
    assign wr_take = avs_write & take;

    // waitrequest high until the answer cycle
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            bus_q           <= rcr_pkg::RCR_BUS_IDLE;
            avs_waitrequest <= 1'b1;
        end else if (req && bus_q == rcr_pkg::RCR_BUS_IDLE) begin
            bus_q           <= rcr_pkg::RCR_BUS_ACK;
            avs_waitrequest <= 1'b0;
        end else begin
            bus_q           <= rcr_pkg::RCR_BUS_IDLE;
            avs_waitrequest <= 1'b1;
        end
    end

    // write decode with byte lanes
    always_comb begin
        status_wr = 16'h0000;
        safety_wr = 8'h00;
        irq_wr    = 8'h00;
        if (wr_take) begin
            unique case (avs_address)
                rcr_pkg::IDX_STATUS: begin
                    if (avs_byteenable[0]) begin
                        status_wr[7:0] = avs_writedata[7:0];
                    end
                    if (avs_byteenable[1]) begin
                        status_wr[15:8] = avs_writedata[15:8];
                    end
                end
                rcr_pkg::IDX_STATUS_HIGH: begin
                    if (avs_byteenable[0]) begin
                        status_wr[15:8] = avs_writedata[7:0];
                    end
                end
                rcr_pkg::IDX_SAFETY: begin
                    if (avs_byteenable[0]) begin
                        safety_wr = avs_writedata[7:0];
                    end
                end
                rcr_pkg::IDX_IRQ_STATUS: begin
                    if (avs_byteenable[0]) begin
                        irq_wr = avs_writedata[7:0];
                    end
                end
                default: begin
                    status_wr = 16'h0000; // unmapped or mask: no flags touched
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // cause, safety and interrupt flags

    logic [15:0] status_q;           // cause status (bit 7 separate)
    logic [7:0]  safety_q;           // safety status
    logic [7:0]  irq_stat_q;         // sticky interrupt status
    logic [7:0]  irq_mask_q;         // interrupt enables
    logic        startup_flag_q;     // start-up abnormality

    genvar gi;
    generate
        for (gi = 0; gi < 16; gi = gi + 1) begin : g_cause
            if (rcr_pkg::CAUSE_MASK[gi]) begin : g_cell
                // power-on wipes every other bit, write one clears
                rcr_flag_cell #(
                    .RESET_VAL (rcr_pkg::STATUS_RESET[gi])
                ) u_cell (
                    .core_clk (core_clk),
                    .reset_n  (reset_n),
                    .wipe     (por_evt && gi != rcr_pkg::BIT_POWER_ON),
                    .set      (cause_set[gi]),
                    .clear    (status_wr[gi]),
                    .flag_q   (status_q[gi])
                );
            end else begin : g_rsvd
                assign status_q[gi] = 1'b0;
            end
        end
        for (gi = 0; gi < 8; gi = gi + 1) begin : g_safe
            if (rcr_pkg::SAFETY_MASK[gi]) begin : g_cell
                rcr_flag_cell #(
                    .RESET_VAL (rcr_pkg::SAFETY_RESET[gi])
                ) u_cell (
                    .core_clk (core_clk),
                    .reset_n  (reset_n),
                    .wipe     (por_evt),
                    .set      (safety_set[gi]),
                    .clear    (safety_wr[gi]),
                    .flag_q   (safety_q[gi])
                );
            end else begin : g_rsvd
                assign safety_q[gi] = 1'b0;
            end
        end
        for (gi = 0; gi < 8; gi = gi + 1) begin : g_irq
            rcr_flag_cell #(
                .RESET_VAL (1'b0)
            ) u_cell (
                .core_clk (core_clk),
                .reset_n  (reset_n),
                .wipe     (1'b0),
                .set      (irq_evt[gi]),
                .clear    (irq_wr[gi]),
                .flag_q   (irq_stat_q[gi])
            );
        end
    endgenerate

    // start-up flag reflects only the latest start-up
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            startup_flag_q <= 1'b0;
        end else if (startup_done) begin
            startup_flag_q <= startup_abnormal;
        end else if (por_evt) begin
            startup_flag_q <= 1'b0;
        end
    end

    // interrupt mask register
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            irq_mask_q <= rcr_pkg::IRQ_MASK_RESET;
        end else if (wr_take && avs_address == rcr_pkg::IDX_IRQ_MASK
                     && avs_byteenable[0]) begin
            irq_mask_q <= avs_writedata[7:0];
        end
    end

    // level interrupt while any unmasked status bit is set
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_stat_q & irq_mask_q);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read path

    logic [15:0] status_view;        // status with start-up bit merged

    always_comb begin
        status_view = status_q;
        status_view[rcr_pkg::BIT_STARTUP] = startup_flag_q;
    end

    // read mux, unmapped reads return zero
    always_comb begin
        rd_d = 32'h0000_0000;
        unique case (avs_address)
            rcr_pkg::IDX_STATUS:      rd_d = {16'h0000, status_view};
            rcr_pkg::IDX_STATUS_HIGH: rd_d = {24'h00_0000, status_view[15:8]};
            rcr_pkg::IDX_SAFETY:      rd_d = {24'h00_0000, safety_q};
            rcr_pkg::IDX_IRQ_STATUS:  rd_d = {24'h00_0000, irq_stat_q};
            rcr_pkg::IDX_IRQ_MASK:    rd_d = {24'h00_0000, irq_mask_q};
            default:                  rd_d = 32'h0000_0000;
        endcase
    end

    // read data captured as the answer cycle opens
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            avs_readdata <= 32'h0000_0000;
        end else if (avs_read && bus_q == rcr_pkg::RCR_BUS_IDLE) begin
            avs_readdata <= rd_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks

    a_por_wipes_others: assert property (@(posedge core_clk) disable iff (!reset_n)
        por_evt |=> (status_q & ~16'h0001) == 16'h0000 && status_q[0])
        else $error("power-on did not leave only bit 0");

    a_por_sets_bit0: assert property (@(posedge core_clk) disable iff (!reset_n)
        debug_cmd_reset |=> status_q[rcr_pkg::BIT_POWER_ON])
        else $error("debug reset did not set bit 0");

    // lone overflow event, no bus clear: only bit 2 may change
    a_cause_retained: assert property (@(posedge core_clk) disable iff (!reset_n)
        (cause_set == (16'h0001 << rcr_pkg::BIT_WDT_OVF) && !wr_take) |=>
        status_q == ($past(status_q) | (16'h0001 << rcr_pkg::BIT_WDT_OVF)))
        else $error("overflow disturbed other cause bits");

    a_wdt_bad_bit: assert property (@(posedge core_clk) disable iff (!reset_n)
        (wdt_bad_clear && !por_evt) |=> status_q[rcr_pkg::BIT_WDT_BAD])
        else $error("bad clear not on bit 3");

    a_supervisor_bit: assert property (@(posedge core_clk) disable iff (!reset_n)
        (supervisor_trip && !por_evt) |=> status_q[rcr_pkg::BIT_SUPERVISOR])
        else $error("supervisor not on bit 4");

    // watches the second stage only, the first may be metastable
    a_pin_hold_flag: assert property (@(posedge core_clk) disable iff (!reset_n)
        ($fell(pin_sync_q) && !por_evt) |=> system_reset_hold && status_q[rcr_pkg::BIT_PIN])
        else $error("pin low did not hold reset");

    a_brk_level: assert property (@(posedge core_clk) disable iff (!reset_n)
        (brk_exec && exception_level < rcr_pkg::BREAK_MIN_LEVEL) |=> !cpu_reset_req)
        else $error("break reset below level two");

    a_brk_flag: assert property (@(posedge core_clk) disable iff (!reset_n)
        (brk_exec && exception_level >= rcr_pkg::BREAK_MIN_LEVEL && !por_evt)
        |=> status_q[rcr_pkg::BIT_BREAK] && cpu_reset_req)
        else $error("break reset not recorded");

    a_clear_one: assert property (@(posedge core_clk) disable iff (!reset_n)
        (wr_take && avs_address == rcr_pkg::IDX_STATUS && avs_byteenable[0] && avs_writedata[2]
         && !wdt_overflow && !por_evt) |=> !status_q[rcr_pkg::BIT_WDT_OVF])
        else $error("write one did not clear");

    a_rsvd_zero: assert property (@(posedge core_clk) disable iff (!reset_n)
        (status_view & 16'hFE22) == 16'h0000)
        else $error("reserved status bit set");

    a_startup_follow: assert property (@(posedge core_clk) disable iff (!reset_n)
        startup_done |=> startup_flag_q == $past(startup_abnormal))
        else $error("start-up flag not loaded");

    a_startup_ro: assert property (@(posedge core_clk) disable iff (!reset_n)
        (!startup_done && !por_evt) |=> $stable(startup_flag_q))
        else $error("start-up flag changed by write");

    a_safety_bits: assert property (@(posedge core_clk) disable iff (!reset_n)
        (ram_parity_error && !por_evt) |=> safety_q[rcr_pkg::BIT_RAM_PARITY])
        else $error("parity not on safety bit 1");

    a_high_alias: assert property (@(posedge core_clk) disable iff (!reset_n)
        (avs_read && bus_q == rcr_pkg::RCR_BUS_IDLE && avs_address == rcr_pkg::IDX_STATUS_HIGH)
        |=> !avs_waitrequest && avs_readdata == {24'h00_0000, $past(status_view[15:8])})
        else $error("high byte read wrong");

    a_safety_byte: assert property (@(posedge core_clk) disable iff (!reset_n)
        (avs_read && bus_q == rcr_pkg::RCR_BUS_IDLE && avs_address == rcr_pkg::IDX_SAFETY)
        |=> avs_readdata[31:8] == 24'h00_0000)
        else $error("safety read above byte");

    c_por_seen:   cover property (@(posedge core_clk) disable iff (!reset_n) por_evt ##1 irq);
    c_pin_reset:  cover property (@(posedge core_clk) disable iff (!reset_n) pin_fall);
    c_clear_all:  cover property (@(posedge core_clk) disable iff (!reset_n)
        wr_take && avs_address == 16'hF058 && avs_writedata[15:0] == 16'hFFFF);
    c_set_clear:  cover property (@(posedge core_clk) disable iff (!reset_n)
        wdt_overflow && status_wr[2]);

endmodule

/* rcr_reset_cause_recorder_test.sv */
`timescale 1ns/1ns
module rcr_reset_cause_recorder_test;
    logic        core_clk = 1'b0, reset_n = 1'b0;  // clock and reset
    logic [15:0] avs_address = 16'h0000;           // bus request
    logic        avs_read = 1'b0, avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0]  avs_byteenable = 4'h0;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        fire = 1'b0;                      // source model command
    logic [3:0]  code = 4'h0;
    logic [1:0]  exception_level = 2'h0, lvl;
    logic        por_detect, debug_cmd_reset, wdt_overflow, wdt_bad_clear;
    logic        supervisor_trip, brk_exec, ram_parity_error, unused_rom_access;
    logic        startup_done, startup_abnormal, reset_pin_n;
    logic        system_reset_hold, cpu_reset_req, irq;
    logic [31:0] exp_q[$], msk_q[$];               // expected reads, oldest first
    int          failures = 0, compares = 0, brk_seen = 0, nbrk = 0, cycles = 0;
    logic [31:0] seed = 32'h0000003D;
    logic [15:0] e;                                // expected cause status
    logic [3:0]  src_code[3] = '{4'h2, 4'h3, 4'h4};
    int          src_bit[3] = '{2, 3, 4};

    always #4 core_clk = ~core_clk;

    rcr_reset_cause_recorder rcr_reset_cause_recorder_inst (.*);
    rcr_source_model rcr_source_model_inst (.*);
    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        x = x ^ (x << 5);
        return x;
    endfunction
    // compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] want, input string what);
        compares++;
        if (got !== want) begin
            failures++;
            $display("mismatch at %0t: %s got %h want %h", $time, what, got, want);
        end
    endtask
    // verdict and end of run
    task automatic results();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // one avalon transfer, held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [15:0] a, input logic [31:0] d,
                       input logic [3:0] be);
        @(posedge core_clk);
        avs_address <= a;
        avs_read <= !w;
        avs_write <= w;
        avs_writedata <= d;
        avs_byteenable <= be;
        // no cycle limit of its own: only the bench timeout ends a wait
        do begin
            @(posedge core_clk);
        end while (avs_waitrequest !== 1'b0);
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic wr(input logic [15:0] a, input logic [3:0] be, input logic [31:0] d);
        bus(1'b1, a, d, be);
    endtask
    task automatic rd(input logic [15:0] a, input logic [3:0] be, input logic [31:0] want,
                      input logic [31:0] m);
        exp_q.push_back(want);
        msk_q.push_back(m);
        bus(1'b0, a, 32'h0, be);
    endtask
    task automatic rs(input logic [15:0] want);
        rd(16'hF058, 4'h3, {16'h0000, want}, 32'h0000FFFF);
    endtask
    // fire one source, let it settle
    task automatic hit(input logic [3:0] c);
        @(posedge core_clk);
        fire <= 1'b1;
        code <= c;
        @(posedge core_clk);
        fire <= 1'b0;
        repeat (12) @(posedge core_clk);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // watcher: read answers against oldest note, break pulses, timeout
    always @(posedge core_clk) begin
        cycles++;
        if (cpu_reset_req === 1'b1) brk_seen++;
        if (avs_read === 1'b1 && avs_waitrequest === 1'b0 && exp_q.size() > 0) begin
            chk(avs_readdata & msk_q.pop_front(), exp_q.pop_front(), "read data");
        end
        if (cycles == 20000) begin
            failures++;
            results();
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        repeat (12) @(posedge core_clk);
        reset_n <= 1'b1;
        rs(16'h0001);
        wr(16'hF058, 4'h3, 32'h0000FFFF);
        rs(16'h0000);
        e = 16'h0000;
        foreach (src_code[i]) begin
            hit(src_code[i]);
            e[src_bit[i]] = 1'b1;
            rs(e);
        end
        // pin reset: hold during low pin, flag set, released after
        @(posedge core_clk);
        fire <= 1'b1;
        code <= 4'hA;
        @(posedge core_clk);
        fire <= 1'b0;
        repeat (4) @(posedge core_clk);
        #1 chk({31'h0, system_reset_hold}, 32'h1, "hold during pin");
        repeat (12) @(posedge core_clk);
        #1 chk({31'h0, system_reset_hold}, 32'h0, "hold after pin");
        e[6] = 1'b1;
        rs(e);
        // break reset at levels one and two, then random levels, bit cleared through the high byte
        for (int i = 0; i < 6; i++) begin
            seed = xs(seed);
            lvl = (i < 2) ? {i[0], ~i[0]} : seed[1:0];
            wr(16'hF059, 4'h1, 32'h00000001);
            exception_level <= lvl;
            hit(4'h5);
            e[8] = lvl[1];
            nbrk += lvl[1];
            rs(e);
        end
        chk(brk_seen, nbrk, "cpu reset pulses");
        wr(16'hF058, 4'h3, 32'h00000000);
        rs(e);
        rd(16'hF059, 4'h1, {24'h0, e[15:8]}, 32'h000000FF);
        wr(16'hF058, 4'h1, 32'h00000004);
        e[2] = 1'b0;
        rs(e);
        hit(4'h1);
        rs(16'h0001);
        hit(4'h9);
        rs(16'h0081);
        wr(16'hF058, 4'h3, 32'h0000FFFF);
        rs(16'h0080);
        hit(4'h8);
        rs(16'h0000);
        hit(4'h9);
        hit(4'h0);
        rs(16'h0001);
        // safety register
        hit(4'h6);
        hit(4'h7);
        rd(16'hF05A, 4'h1, 32'h00000003, 32'h000000FF);
        wr(16'hF05A, 4'h1, 32'h000000FF);
        rd(16'hF05A, 4'h1, 32'h00000000, 32'h000000FF);
        rd(16'hF05B, 4'h1, 32'h00000000, 32'hFFFFFFFF);
        // interrupt: masked event silent, unmasked raises, clear drops
        wr(16'hF060, 4'h1, 32'h000000FF);
        wr(16'hF061, 4'h1, 32'h00000002);
        hit(4'h4);
        chk({31'h0, irq}, 32'h0, "irq masked");
        hit(4'h2);
        chk({31'h0, irq}, 32'h1, "irq raised");
        rd(16'hF060, 4'h1, 32'h0000000A, 32'h000000FF);
        wr(16'hF060, 4'h1, 32'h00000002);
        repeat (3) @(posedge core_clk);
        chk({31'h0, irq}, 32'h0, "irq cleared");
        repeat (4) @(posedge core_clk);
        results();
    end
endmodule

/* rcr_source_model.sv */
`timescale 1ns/1ns
// reset sources: one-cycle pulses on command, pin held low for a stretch
module rcr_source_model (
    input  wire logic       core_clk,
    input  wire logic       reset_n,
    input  wire logic       fire,
    input  wire logic [3:0] code,
    output logic            por_detect,
    output logic            debug_cmd_reset,
    output logic            wdt_overflow,
    output logic            wdt_bad_clear,
    output logic            supervisor_trip,
    output logic            brk_exec,
    output logic            ram_parity_error,
    output logic            unused_rom_access,
    output logic            startup_done,
    output logic            startup_abnormal,
    output logic            reset_pin_n
);
    logic [3:0] pin_cnt_q;  // cycles left with the pin low
    ////////////////////////////////////////////////////////////////////////////
    // one pulse per command code
    always_ff @(posedge core_clk) begin
        por_detect        <= fire && code == 4'h0;
        debug_cmd_reset   <= fire && code == 4'h1;
        wdt_overflow      <= fire && code == 4'h2;
        wdt_bad_clear     <= fire && code == 4'h3;
        supervisor_trip   <= fire && code == 4'h4;
        brk_exec          <= fire && code == 4'h5;
        ram_parity_error  <= fire && code == 4'h6;
        unused_rom_access <= fire && code == 4'h7;
        startup_done      <= fire && code[3:1] == 3'h4;
    end
    // abnormal level valid with done only, flipped every cycle otherwise
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            startup_abnormal <= 1'b0;
        end else if (fire && code[3:1] == 3'h4) begin
            startup_abnormal <= code[0];
        end else begin
            startup_abnormal <= ~startup_abnormal;
        end
    end
    // pin held low, then released high
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            pin_cnt_q <= 4'h0;
        end else if (fire && code == 4'hA) begin
            pin_cnt_q <= 4'h6;
        end else if (pin_cnt_q != 4'h0) begin
            pin_cnt_q <= pin_cnt_q - 4'h1;
        end
    end
    assign reset_pin_n = (pin_cnt_q == 4'h0);
endmodule
